// [rtl/tofbc_ctrl.sv]
// Purpose: boot, standby and ranging cadence control of a ranging sensor
// Assumes: one 50 MHz clock; shutdown pin and measurement input are asynchronous
// Notes:   distance value comes from the ranging core on meas_*_i
// Notes on behaviour
// R1: while the shutdown input is low the block sits in hardware standby.
// R2: a rising shutdown input leads through firmware boot into software standby.
// R3: with shutdown tied high the block boots straight to software standby within 1.2 ms.
// R4: the host raises the shutdown input only once the main supply is present.
// R5: once started, ranging repeats at 60 Hz, each operation lasting 16 ms by default.
// R6: the length of each measurement follows the user timing budget.
// R7: in ranging, multizone and lite modes each result must be read before the next operation.
// R8: with no target or weak signal an error status code is left for the host to read; the code flags only a zero distance.
// R9: autonomous mode interrupts only on threshold hits and spaces operations by an interval.
// R10: the region of interest spans 4x4 up to 16x16 elements.
// R11: multizone mode ranges the selected zones one after another, up to 16.
// R12: the interrupt output rises on a ready result and clears on host read; ranging holds meanwhile.
// R13: in hardware standby the serial register port is not answered.
// R14: no ranging starts before boot has finished and software standby is reached.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tofbc_ctrl
    import tofbc_pkg::*;
#(
    parameter int unsigned BOOT_CYCLES   = BOOT_CYC,
    parameter int unsigned DEF_BUDGET    = OP_CYC,
    parameter int unsigned DEF_PERIOD    = PERIOD_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    shutdown_n_input_i,
    input  wire logic [7:0]              addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [31:0]             rdata_o,
    input  wire logic [15:0]             meas_dist_i,
    input  wire logic                    meas_valid_i,
    output logic                         interrupt_output_o,
    output logic                         standby_hw_o,
    output logic                         ranging_o,
    output logic      [3:0]              zone_o
);
    import tofbc_pkg::*;

    typedef enum logic [2:0] {
        ST_HW_STANDBY, ST_BOOT, ST_SW_STANDBY, ST_MEASURE, ST_WAIT_READ, ST_GAP
    } tofbc_state_e;

    tofbc_state_e state_ff;
    logic         shut_s1_ff;
    logic         shut_s2_ff;
    logic         mvalid_s1_ff;
    logic         mvalid_s2_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] period_ff;
    logic         start_ff;
    tofbc_mode_e  mode_ff;
    logic [CNT_W-1:0] budget_ff;
    logic [CNT_W-1:0] interval_ff;
    logic [4:0]   roi_w_ff;
    logic [4:0]   roi_h_ff;
    logic [4:0]   zones_ff;
    logic [15:0]  thr_lo_ff;
    logic [15:0]  thr_hi_ff;
    logic [15:0]  dist_ff;
    logic [3:0]   err_ff;
    logic [15:0]  dist_s1_ff;
    logic [15:0]  dsync_ff;
    logic [3:0]   res_zone_ff;
    logic         irq_ff;
    logic [3:0]   zone_ff;
    logic         reg_ok;
    logic         rd_result;
    logic         hit;
    logic         meas_done;
    logic [4:0]   roi_w_clip;
    logic [4:0]   roi_h_clip;
    logic [4:0]   zones_clip;

    // pin and async core inputs pass two flops before use
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shut_s1_ff   <= 1'b0;
            shut_s2_ff   <= 1'b0;
            mvalid_s1_ff <= 1'b0;
            mvalid_s2_ff <= 1'b0;
        end else begin
            shut_s1_ff   <= shutdown_n_input_i;
            shut_s2_ff   <= shut_s1_ff;
            mvalid_s1_ff <= meas_valid_i;
            mvalid_s2_ff <= mvalid_s1_ff;
        end
    end

    // same two-flop depth as valid, so distance is settled when valid shows
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dist_s1_ff <= 16'h0000;
            dsync_ff   <= 16'h0000;
        end else begin
            dist_s1_ff <= meas_dist_i;
            dsync_ff   <= dist_s1_ff;
        end
    end

    // register port closed in hardware standby and during boot
    assign reg_ok    = (state_ff != ST_HW_STANDBY) && (state_ff != ST_BOOT); // R13
    assign rd_result = reg_ok && rd_i && (addr_i == ADDR_RESULT);
    assign meas_done = (state_ff == ST_MEASURE) && (cnt_ff >= budget_ff) && mvalid_s2_ff;
    assign hit       = (dsync_ff >= thr_lo_ff) && (dsync_ff <= thr_hi_ff)
                       && (dsync_ff != 16'h0000);

    assign roi_w_clip = (wdata_i[4:0] < ROI_MIN) ? ROI_MIN :
                        (wdata_i[4:0] > ROI_MAX) ? ROI_MAX : wdata_i[4:0]; // R10
    assign roi_h_clip = (wdata_i[12:8] < ROI_MIN) ? ROI_MIN :
                        (wdata_i[12:8] > ROI_MAX) ? ROI_MAX : wdata_i[12:8]; // R10
    assign zones_clip = (wdata_i[4:0] == 5'h00) ? 5'h01 :
                        (wdata_i[4:0] > ZONES_MAX) ? ZONES_MAX : wdata_i[4:0]; // R11

    // configuration registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_ff    <= 1'b0;
            mode_ff     <= TOFBC_MODE_RANGING;
            budget_ff   <= CNT_W'(DEF_BUDGET);
            interval_ff <= CNT_W'(DEF_PERIOD);
            period_ff   <= CNT_W'(DEF_PERIOD);
            roi_w_ff    <= ROI_MAX;
            roi_h_ff    <= ROI_MAX;
            zones_ff    <= 5'h01;
            thr_lo_ff   <= 16'h0000;
            thr_hi_ff   <= 16'hffff;
        end else if (!shut_s2_ff) begin
            start_ff    <= 1'b0;
        end else if (wr_i && reg_ok) begin
            case (addr_i)
                ADDR_CTRL: begin
                    start_ff <= wdata_i[CTRL_START];
                    mode_ff  <= tofbc_mode_e'(wdata_i[CTRL_MODE_LO +: 2]);
                end
                ADDR_BUDGET:   budget_ff   <= (wdata_i == 32'h0) ? 32'h1 : wdata_i; // R6
                ADDR_INTERVAL: interval_ff <= (wdata_i == 32'h0) ? 32'h1 : wdata_i; // R9
                ADDR_ROI: begin
                    roi_w_ff <= roi_w_clip;
                    roi_h_ff <= roi_h_clip;
                end
                ADDR_ZONES:    zones_ff    <= zones_clip;
                ADDR_THRESH: begin
                    thr_lo_ff <= wdata_i[15:0];
                    thr_hi_ff <= wdata_i[31:16];
                end
                default: ;
            endcase
        end
    end

    // state machine: boot, standby, measure, wait for read, idle gap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_HW_STANDBY;
            cnt_ff   <= '0;
        end else if (!shut_s2_ff) begin
            state_ff <= ST_HW_STANDBY; // R1
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                ST_HW_STANDBY: begin
                    state_ff <= ST_BOOT; // R2 R3
                    cnt_ff   <= '0;
                end
                ST_BOOT: begin
                    if (cnt_ff >= CNT_W'(BOOT_CYCLES - 1)) begin
                        state_ff <= ST_SW_STANDBY; // R3
                        cnt_ff   <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                ST_SW_STANDBY: begin
                    cnt_ff <= '0;
                    if (start_ff) begin
                        state_ff <= ST_MEASURE; // R14
                    end
                end
                ST_MEASURE: begin
                    cnt_ff <= cnt_ff + 1'b1; // R6
                    if (meas_done) begin
                        cnt_ff <= '0;
                        if (mode_ff == TOFBC_MODE_AUTO && !hit) begin
                            state_ff <= ST_GAP; // R9
                        end else begin
                            state_ff <= ST_WAIT_READ; // R7 R12
                        end
                    end
                end
                ST_WAIT_READ: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (!start_ff) begin
                        state_ff <= ST_SW_STANDBY;
                    end else if (rd_result) begin
                        state_ff <= ST_GAP; // R7
                    end
                end
                ST_GAP: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (!start_ff) begin
                        state_ff <= ST_SW_STANDBY;
                    end else if (cnt_ff >= ((mode_ff == TOFBC_MODE_AUTO) ? interval_ff
                                 : (period_ff > budget_ff ? period_ff - budget_ff : 32'h1))) begin
                        state_ff <= ST_MEASURE; // R5 R9
                        cnt_ff   <= '0;
                    end
                end
                default: begin
                    state_ff <= ST_HW_STANDBY;
                    cnt_ff   <= '0;
                end
            endcase
        end
    end

    // result, error code and zone walk
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dist_ff <= 16'h0000;
            err_ff  <= ERR_NONE;
            zone_ff <= 4'h0;
            res_zone_ff <= 4'h0;
        end else if (state_ff == ST_SW_STANDBY) begin
            zone_ff <= 4'h0;
        end else if (meas_done) begin
            dist_ff <= dsync_ff;
            // result keeps the zone just measured, the walk moves on
            res_zone_ff <= zone_ff; // R11
            err_ff  <= (dsync_ff == 16'h0000) ? ERR_NO_TARGET : ERR_NONE; // R8
            if (mode_ff == TOFBC_MODE_MULTIZONE && ({1'b0, zone_ff} + 5'h01) < zones_ff) begin
                zone_ff <= zone_ff + 4'h1; // R11
            end else begin
                zone_ff <= 4'h0;
            end
        end
    end

    // interrupt: set on ready result, cleared by the result read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ff <= 1'b0;
        end else if (meas_done && (mode_ff != TOFBC_MODE_AUTO || hit)) begin
            irq_ff <= 1'b1; // R12 R9
        end else if (rd_result || state_ff == ST_HW_STANDBY) begin
            irq_ff <= 1'b0; // R12
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i && reg_ok) begin
            case (addr_i)
                ADDR_CTRL:     rdata_o <= {29'h0, mode_ff, start_ff};
                ADDR_BUDGET:   rdata_o <= budget_ff;
                ADDR_INTERVAL: rdata_o <= interval_ff;
                ADDR_ROI:      rdata_o <= {19'h0, roi_h_ff, 3'h0, roi_w_ff};
                ADDR_ZONES:    rdata_o <= {27'h0, zones_ff};
                ADDR_THRESH:   rdata_o <= {thr_hi_ff, thr_lo_ff};
                ADDR_STATUS:   rdata_o <= {23'h0, irq_ff, zone_ff, 3'(state_ff), err_ff == ERR_NONE};
                ADDR_RESULT:   rdata_o <= {8'h0, res_zone_ff, err_ff, dist_ff}; // R8
                default:       rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0; // R13
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_output_o <= 1'b0;
            standby_hw_o       <= 1'b1;
            ranging_o          <= 1'b0;
            zone_o             <= 4'h0;
        end else begin
            interrupt_output_o <= irq_ff;
            standby_hw_o       <= (state_ff == ST_HW_STANDBY);
            ranging_o          <= (state_ff == ST_MEASURE);
            zone_o             <= zone_ff;
        end
    end

    // assertions
    property p_standby_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !shut_s2_ff |=> state_ff == ST_HW_STANDBY;
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("not in standby"); // R1

    property p_boot_after_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_HW_STANDBY && shut_s2_ff) |=> state_ff == ST_BOOT;
    endproperty
    a_boot_after_rise: assert property (p_boot_after_rise) else $error("no boot"); // R2

    property p_boot_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_BOOT && cnt_ff == CNT_W'(BOOT_CYCLES - 1) && shut_s2_ff)
            |=> state_ff == ST_SW_STANDBY;
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot too long"); // R3

    property p_no_early;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_BOOT) |=> state_ff != ST_MEASURE;
    endproperty
    a_no_early: assert property (p_no_early) else $error("ranging before boot"); // R14

    property p_hold_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_WAIT_READ && start_ff && shut_s2_ff && !rd_result)
            |=> state_ff == ST_WAIT_READ;
    endproperty
    a_hold_irq: assert property (p_hold_irq) else $error("ranging not held"); // R7

    property p_irq_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        (meas_done && mode_ff != TOFBC_MODE_AUTO) |=> irq_ff ##1 interrupt_output_o;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not raised"); // R12

    property p_irq_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_result && !meas_done) |=> !irq_ff;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared"); // R12

    property p_auto_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        (meas_done && mode_ff == TOFBC_MODE_AUTO && !hit && !irq_ff) |=> !irq_ff;
    endproperty
    a_auto_quiet: assert property (p_auto_quiet) else $error("auto irq w/o hit"); // R9

    property p_err_code;
        @(posedge clk_i) disable iff (!rst_n_i)
        (meas_done && dsync_ff == 16'h0000) |=> err_ff == ERR_NO_TARGET;
    endproperty
    a_err_code: assert property (p_err_code) else $error("no error code"); // R8

    property p_silent;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_HW_STANDBY) |=> rdata_o == 32'h0;
    endproperty
    a_silent: assert property (p_silent) else $error("bus answered in standby"); // R13

    property p_roi;
        @(posedge clk_i) disable iff (!rst_n_i)
        roi_w_ff >= ROI_MIN && roi_w_ff <= ROI_MAX && roi_h_ff >= ROI_MIN && roi_h_ff <= ROI_MAX;
    endproperty
    a_roi: assert property (p_roi) else $error("roi out of range"); // R10
endmodule
`default_nettype wire

// [rtl/tofbc_pkg.sv]
// Purpose: shared constants for the ranging boot and cadence controller
// Assumes: 50 MHz clock
// Notes:   times are kept in their own unit, cycle counts derive from them
package tofbc_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned BOOT_TIME_US10  = 12;      // 1.2 ms in units of 100 us
    localparam int unsigned BOOT_CYC        = (CLK_HZ / 10_000) * BOOT_TIME_US10;
    localparam int unsigned RATE_HZ         = 60;
    localparam int unsigned PERIOD_CYC      = CLK_HZ / RATE_HZ;
    localparam int unsigned OP_TIME_MS      = 16;
    localparam int unsigned OP_CYC          = (CLK_HZ / 1000) * OP_TIME_MS;
    localparam int unsigned CNT_W           = 32;

    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_BUDGET      = 8'h04;
    localparam logic [7:0] ADDR_INTERVAL    = 8'h08;
    localparam logic [7:0] ADDR_ROI         = 8'h0c;
    localparam logic [7:0] ADDR_ZONES       = 8'h10;
    localparam logic [7:0] ADDR_THRESH      = 8'h14;
    localparam logic [7:0] ADDR_STATUS      = 8'h18;
    localparam logic [7:0] ADDR_RESULT      = 8'h1c;

    localparam logic [4:0] ROI_MIN          = 5'h04;
    localparam logic [4:0] ROI_MAX          = 5'h10;
    localparam logic [4:0] ZONES_MAX        = 5'h10;

    localparam logic [3:0] ERR_NONE         = 4'h0;
    localparam logic [3:0] ERR_NO_TARGET    = 4'h4;

    localparam int unsigned CTRL_START      = 0;
    localparam int unsigned CTRL_MODE_LO    = 1;

    typedef enum logic [1:0] {
        TOFBC_MODE_RANGING,
        TOFBC_MODE_MULTIZONE,
        TOFBC_MODE_LITE,
        TOFBC_MODE_AUTO
    } tofbc_mode_e;
endpackage

// [tb/tb_tof_ranging_boot_control.sv]
// Purpose: self-checking bench for the boot and ranging cadence controller
// Assumes: shortened boot, budget and period parameters
// Notes:   result word taken as {distance, error, zone} from bit 0 up
`timescale 1ns/100ps
`default_nettype none
module tb_tof_ranging_boot_control;
    import tofbc_pkg::*;
    localparam int unsigned BOOT   = 20;
    localparam int unsigned PERIOD = 60;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        shutdown_n_input_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [15:0] meas_dist_i;
    logic        meas_valid_i;
    logic        interrupt_output_o;
    logic        standby_hw_o;
    logic        ranging_o;
    logic [3:0]  zone_o;
    logic [15:0] dist_set = 16'h0;
    logic [7:0]  delay_set = 8'h00;
    logic [31:0] v;
    int          seed = 32'h6a48;
    int          failures = 0;
    int          num_checks = 0;
    int          waited;
    int          budget;

    always #10 clk_i = ~clk_i;

    tofbc_ctrl #(.BOOT_CYCLES(BOOT), .DEF_BUDGET(30), .DEF_PERIOD(PERIOD)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .shutdown_n_input_i(shutdown_n_input_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .meas_dist_i(meas_dist_i), .meas_valid_i(meas_valid_i),
        .interrupt_output_o(interrupt_output_o), .standby_hw_o(standby_hw_o),
        .ranging_o(ranging_o), .zone_o(zone_o));

    tofbc_core_model i_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ranging_i(ranging_o), .dist_i(dist_set),
        .delay_i(delay_set), .meas_dist_o(meas_dist_i), .meas_valid_o(meas_valid_i));

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // sample after the edge's updates have landed
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    function automatic logic sig(input int sel);
        return sel == 0 ? interrupt_output_o : (sel == 1 ? ranging_o : standby_hw_o);
    endfunction

    task automatic wait_on(input int sel, input logic lvl, input int lim);
        for (waited = 0; waited < lim && sig(sel) !== lvl; waited++) begin
            tick();
        end
        if (waited == lim) begin
            failures++;
            end_of_test();
        end
    endtask

    task automatic measure(input logic [15:0] d, input logic [3:0] z, input bit gap);
        int c;
        dist_set  <= d;
        delay_set <= 8'($unsigned($random(seed)) % 48);
        wait_on(1, 1'b1, 4 * PERIOD);
        if (gap) begin
            check(32'(waited >= PERIOD - budget - 5 && waited <= PERIOD - budget + 3), 1);
        end
        check(zone_o, z);
        for (c = 0; c < 200 && ranging_o; c++) begin
            tick();
        end
        check(32'(c >= budget), 1);
        wait_on(0, 1'b1, 4);
        repeat (3) tick();
        check(ranging_o, 0);
        rd(ADDR_RESULT);
        check(v, {8'h00, z, d == 16'h0 ? ERR_NO_TARGET : ERR_NONE, d});
        wait_on(0, 1'b0, 3);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (8) tick();
        check(standby_hw_o, 1);
        wr(ADDR_ZONES, 32'h2);
        rd(ADDR_ZONES);
        check(v, 0);
        shutdown_n_input_i <= 1'b1;
        wait_on(2, 1'b0, 6);
        // start during boot must be lost
        wr(ADDR_CTRL, 32'h1);
        repeat (BOOT) tick();
        check(ranging_o, 0);
        repeat (4) tick();
        budget = 20 + int'($unsigned($random(seed)) % 21);
        wr(ADDR_BUDGET, 32'(budget));
        for (int m = 0; m < 3; m += 2) begin
            wr(ADDR_CTRL, {29'h0, 2'(m), 1'b1});
            for (int k = 0; k < 3; k++) begin
                measure(k == 2 ? 16'h0 : 16'($unsigned($random(seed)) % 4000 + 1), 4'h0, k > 0);
            end
            wr(ADDR_CTRL, 32'h0);
        end
        wr(ADDR_ROI, 32'h1402);
        rd(ADDR_ROI);
        check(v, 32'h1004);
        wr(ADDR_ROI, 32'h0808);
        rd(ADDR_ROI);
        check(v, 32'h0808);
        rd(8'h20);
        check(v, 0);
        wr(ADDR_ZONES, 32'h4);
        wr(ADDR_CTRL, {29'h0, TOFBC_MODE_MULTIZONE, 1'b1});
        for (int k = 0; k < 4; k++) begin
            measure(16'(300 + k), 4'(k), 1'b0);
        end
        // shutdown held high across reset: straight into boot
        rst_n_i <= 1'b0;
        repeat (2) tick();
        rst_n_i <= 1'b1;
        wait_on(2, 1'b0, 6);
        repeat (BOOT + 4) tick();
        wr(ADDR_INTERVAL, 32'd40);
        // reset restored the default budget; put back the one checked against
        wr(ADDR_BUDGET, 32'(budget));
        rd(ADDR_BUDGET);
        check(v, 32'(budget));
        wr(ADDR_THRESH, {16'd200, 16'd100});
        wr(ADDR_CTRL, {29'h0, TOFBC_MODE_AUTO, 1'b1});
        dist_set <= 16'd50;
        for (int k = 0; k < 2; k++) begin
            wait_on(1, 1'b1, 200);
            wait_on(1, 1'b0, 200);
            repeat (3) tick();
            check(interrupt_output_o, 0);
        end
        measure(16'd150, 4'h0, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire

// [tb/tofbc_core_model.sv]
// Purpose: ranging core stand-in feeding distance results to the controller
// Assumes: result offered delay_i cycles after measuring starts
// Notes:   distance lines toggle once released, so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module tofbc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ranging_i,
    input  wire logic [15:0] dist_i,
    input  wire logic [7:0]  delay_i,
    output logic      [15:0] meas_dist_o,
    output logic             meas_valid_o
);
    logic [7:0] wait_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_ff      <= 8'h00;
            meas_valid_o <= 1'b0;
            meas_dist_o  <= 16'h0000;
        end else if (!ranging_i) begin
            wait_ff      <= 8'h00;
            meas_valid_o <= 1'b0;
            meas_dist_o  <= ~meas_dist_o;
        end else if (wait_ff < delay_i) begin
            wait_ff <= wait_ff + 8'h01;
        end else begin
            meas_valid_o <= 1'b1;
            meas_dist_o  <= dist_i;
        end
    end
endmodule
`default_nettype wire
